//--- acom_pkg.sv
// Package for the cell OAM monitor: constants, states and message carriers
package acom_pkg;

  // Delineation process states supplied from outside
  typedef enum logic [1:0] {
    ACOM_HUNT    = 2'b00,
    ACOM_PRESYNC = 2'b01,
    ACOM_SYNC    = 2'b10
  } acom_delin_t;

  // Message transmit sequencer states
  typedef enum logic [2:0] {
    ACOM_TX_IDLE = 3'b000,
    ACOM_TX_ID   = 3'b001,
    ACOM_TX_FLAG = 3'b010,
    ACOM_TX_HI   = 3'b011,
    ACOM_TX_LO   = 3'b100
  } acom_tx_t;

  // Message identifiers
  localparam logic [7:0] ACOM_ID_REQ    = 8'h11;
  localparam logic [7:0] ACOM_ID_STATUS = 8'h91;

  // Status flag octet field positions
  localparam int ACOM_B_NCD_IND  = 7;
  localparam int ACOM_B_OCD_IND  = 6;
  localparam int ACOM_B_LCD_IND  = 5;
  localparam int ACOM_B_NCD_FAIL = 1;
  localparam int ACOM_B_LCD_FAIL = 0;

  // Timing
  localparam longint ACOM_CLK_HZ       = 200_000_000;
  localparam longint ACOM_DECLARE_MS   = 2500;
  localparam longint ACOM_CLEAR_MS     = 10000;
  localparam longint ACOM_RESEND_MS    = 1000;
  localparam longint ACOM_TICK_MS      = 100;
  localparam longint ACOM_TICK_CYC     = ACOM_CLK_HZ * ACOM_TICK_MS / 1000;
  localparam logic [7:0] ACOM_DECLARE_TICKS = 8'(ACOM_DECLARE_MS / ACOM_TICK_MS);
  localparam logic [7:0] ACOM_CLEAR_TICKS   = 8'(ACOM_CLEAR_MS / ACOM_TICK_MS);
  localparam logic [7:0] ACOM_RESEND_TICKS  = 8'(ACOM_RESEND_MS / ACOM_TICK_MS);
  localparam logic [3:0] ACOM_LCD_FRAMES    = 4'h9;

  // Outgoing status message content
  typedef struct packed {
    logic [7:0]  flags;
    logic [15:0] hvc;
  } acom_status_t;

  // Octet stream carrier
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       last;
  } acom_octet_t;

endpackage : acom_pkg

//--- acom_monitor.sv
// Cell delineation OAM monitor: counters, failures and status messaging
`timescale 1ns/100ps
// Functional notes
// R1 - Sixteen-bit header violation counter, wraps
// R2 - Count cells seen while in sync
// R3 - Counts readable live for interval collection
// R4 - Near no-delineation failure: 2.5 s / 10 s
// R5 - Near loss failure: 2.5 s / 10 s
// R6 - Far no-delineation failure: 2.5 s / 10 s
// R7 - Far loss failure: 2.5 s / 10 s
// R8 - Near and far failures provided, no-delineation ones in data mode only
// R9 - Request 17 answered by status 145
// R10 - Request 17 stops autonomous repeats
// R11 - Near failure sends 145, repeats each second
// R12 - Status octets: id, flags, counter high/low
// R13 - Indicator and failure bits mirror states
// R14 - Header error inferred from counter change
// R15 - At most one indicator bit set
// R16 - No-delineation from start until first sync
// R17 - Out-of-delineation on sync to hunt
// R18 - Loss defect after nine frames, no sync-loss
// R19 - Far no-delineation ends on received zero
// R20 - Timers share one derived tick
module acom_monitor
  import acom_pkg::*;
#(
  parameter longint TICK_CYC = ACOM_TICK_CYC
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        clk_en,
  input  wire logic        data_mode,
  input  acom_delin_t      delin_state,
  input  wire logic        cell_valid,
  input  wire logic        hec_error,
  input  wire logic        frame_strobe,
  input  wire logic        sync_word_lost,
  input  acom_octet_t      rx_octet,
  output acom_octet_t      tx_octet,
  input  wire logic        tx_ready,
  output logic [15:0]      hvc_count,
  output logic [31:0]      htc_count,
  input  wire logic        htc_clear,
  output logic             no_delin_flag,
  output logic             out_delin_flag,
  output logic             loss_delin_flag,
  output logic             near_ncd_fail,
  output logic             near_lcd_fail,
  output logic             far_ncd_fail,
  output logic             far_lcd_fail
);

  ////////////////////////////////////////////////////////////////////////////
  // Seconds-scale tick
  logic [31:0] tick_cnt_q;
  logic        tick;

  // R20 common tick
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tick_cnt_q <= 32'h0000_0000;
    end else if (clk_en) begin
      if (tick_cnt_q == 32'(TICK_CYC - 1)) begin
        tick_cnt_q <= 32'h0000_0000;
      end else begin
        tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
      end
    end
  end
  assign tick = clk_en && (tick_cnt_q == 32'(TICK_CYC - 1));

  ////////////////////////////////////////////////////////////////////////////
  // Performance counters
  // R1 wrapping violation count
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hvc_count <= 16'h0000;
    end else if (clk_en && hec_error) begin
      hvc_count <= hvc_count + 16'h0001;
    end
  end

  // R2 cells in sync, R3 clear by reader
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      htc_count <= 32'h0000_0000;
    end else if (clk_en) begin
      if (cell_valid && delin_state == ACOM_SYNC) begin
        htc_count <= (htc_clear ? 32'h0000_0000 : htc_count) + 32'h0000_0001;
      end else if (htc_clear) begin
        htc_count <= 32'h0000_0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Near-end anomalies and defect
  logic        acquired_q;
  acom_delin_t prev_state_q;
  logic        ocd_event;
  logic        ocd_in_frame_q;
  logic [3:0]  lcd_run_q;

  assign ocd_event = prev_state_q == ACOM_SYNC && delin_state == ACOM_HUNT;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      acquired_q   <= 1'b0;
      prev_state_q <= ACOM_HUNT;
    end else if (clk_en) begin
      prev_state_q <= delin_state;
      if (delin_state == ACOM_SYNC) begin
        acquired_q <= 1'b1;
      end
    end
  end

  // R16 until first sync
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      no_delin_flag <= 1'b1;
    end else if (clk_en) begin
      no_delin_flag <= !acquired_q && delin_state != ACOM_SYNC;
    end
  end

  // R17 sync to hunt, ends on resync or loss defect
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      out_delin_flag <= 1'b0;
    end else if (clk_en) begin
      if (ocd_event) begin
        out_delin_flag <= 1'b1;
      end else if (delin_state == ACOM_SYNC || loss_delin_flag) begin
        out_delin_flag <= 1'b0;
      end
    end
  end

  // R18 nine consecutive frames
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ocd_in_frame_q  <= 1'b0;
      lcd_run_q       <= 4'h0;
      loss_delin_flag <= 1'b0;
    end else if (clk_en) begin
      if (frame_strobe) begin
        ocd_in_frame_q <= ocd_event;
        if ((ocd_in_frame_q || ocd_event || out_delin_flag) && !sync_word_lost) begin
          if (lcd_run_q != ACOM_LCD_FRAMES) begin
            lcd_run_q <= lcd_run_q + 4'h1;
          end
          loss_delin_flag <= (lcd_run_q + 4'h1) >= ACOM_LCD_FRAMES;
        end else begin
          lcd_run_q       <= 4'h0;
          loss_delin_flag <= 1'b0;
        end
      end else if (ocd_event) begin
        ocd_in_frame_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Far-end state from received status messages
  logic [1:0] rx_pos_q;
  logic       rx_is_status_q;
  logic       far_ncd_q;
  logic       far_lcd_q;
  logic       req_seen;

  assign req_seen = rx_octet.valid && rx_pos_q == 2'd0 && rx_octet.data == ACOM_ID_REQ;

  // R19 far anomaly until coded zero
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_pos_q       <= 2'd0;
      rx_is_status_q <= 1'b0;
      far_ncd_q      <= 1'b1;
      far_lcd_q      <= 1'b0;
    end else if (clk_en && rx_octet.valid) begin
      rx_pos_q <= rx_octet.last ? 2'd0 : rx_pos_q + 2'd1;
      if (rx_pos_q == 2'd0) begin
        rx_is_status_q <= rx_octet.data == ACOM_ID_STATUS;
      end else if (rx_pos_q == 2'd1 && rx_is_status_q) begin
        far_ncd_q <= rx_octet.data[ACOM_B_NCD_IND];
        far_lcd_q <= rx_octet.data[ACOM_B_LCD_IND];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Persistence timers
  function automatic logic [7:0] acom_step(input logic [7:0] cnt, input logic cond,
                                           input logic [7:0] lim);
    acom_step = !cond ? 8'h00 : (cnt == lim ? cnt : cnt + 8'h01);
  endfunction : acom_step

  logic [3:0] fail_q;
  logic [3:0] defect;
  logic [7:0] set_cnt_q [4];
  logic [7:0] clr_cnt_q [4];

  assign defect = {far_lcd_q, far_ncd_q && data_mode, loss_delin_flag,
                   no_delin_flag && data_mode};

  // R4 R5 R6 R7 R8 declare and clear
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fail_q <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        set_cnt_q[i] <= 8'h00;
        clr_cnt_q[i] <= 8'h00;
      end
    end else if (tick) begin
      for (int i = 0; i < 4; i++) begin
        set_cnt_q[i] <= acom_step(set_cnt_q[i], defect[i], ACOM_DECLARE_TICKS);
        clr_cnt_q[i] <= acom_step(clr_cnt_q[i], !defect[i], ACOM_CLEAR_TICKS);
        if (defect[i] && set_cnt_q[i] >= ACOM_DECLARE_TICKS) begin
          fail_q[i] <= 1'b1;
        end else if (!defect[i] && clr_cnt_q[i] >= ACOM_CLEAR_TICKS) begin
          fail_q[i] <= 1'b0;
        end
      end
    end
  end

  assign near_ncd_fail = fail_q[0];
  assign near_lcd_fail = fail_q[1];
  assign far_ncd_fail  = fail_q[2];
  assign far_lcd_fail  = fail_q[3];

  ////////////////////////////////////////////////////////////////////////////
  // Status message sender
  acom_tx_t     tx_state_q;
  acom_status_t snap_q;
  logic         req_pend_q;
  logic         auto_pend_q;
  logic         acked_q;
  logic [1:0]   near_fail_q;
  logic [7:0]   resend_q;
  logic [7:0]   flags_now;
  logic         near_any;

  assign near_any = near_ncd_fail || near_lcd_fail;

  // R12 R13 R15 single indicator, priority order
  always_comb begin
    flags_now = 8'h00;
    if (no_delin_flag) begin
      flags_now[ACOM_B_NCD_IND] = 1'b1;
    end else if (loss_delin_flag) begin
      flags_now[ACOM_B_LCD_IND] = 1'b1;
    end else if (out_delin_flag) begin
      flags_now[ACOM_B_OCD_IND] = 1'b1;
    end
    flags_now[ACOM_B_NCD_FAIL] = near_ncd_fail;
    flags_now[ACOM_B_LCD_FAIL] = near_lcd_fail;
  end

  // R9 R10 R11 request and repeat pacing
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      req_pend_q  <= 1'b0;
      auto_pend_q <= 1'b0;
      acked_q     <= 1'b0;
      near_fail_q <= 2'b00;
      resend_q    <= 8'h00;
    end else if (clk_en) begin
      near_fail_q <= {near_lcd_fail, near_ncd_fail};
      if (({near_lcd_fail, near_ncd_fail} & ~near_fail_q) != 2'b00) begin
        acked_q     <= 1'b0;
        auto_pend_q <= 1'b1;
        resend_q    <= 8'h00;
      end else if (req_seen || !near_any) begin
        acked_q     <= near_any;
        auto_pend_q <= 1'b0;
      end else if (tick && !acked_q) begin
        resend_q <= (resend_q + 8'h01 == ACOM_RESEND_TICKS) ? 8'h00 : resend_q + 8'h01;
        if (resend_q + 8'h01 == ACOM_RESEND_TICKS) begin
          auto_pend_q <= 1'b1;
        end
      end
      if (req_seen) begin
        req_pend_q <= 1'b1;
      end
      if (tx_state_q == ACOM_TX_ID && tx_ready) begin
        req_pend_q <= req_seen;
        if (!req_seen && !(({near_lcd_fail, near_ncd_fail} & ~near_fail_q) != 2'b00)) begin
          auto_pend_q <= 1'b0;
        end
      end
    end
  end

  // R12 R14 octet sequence, counter sent raw
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_state_q <= ACOM_TX_IDLE;
      snap_q     <= '0;
    end else if (clk_en) begin
      case (tx_state_q)
        ACOM_TX_IDLE: begin
          if (req_pend_q || auto_pend_q) begin
            snap_q     <= '{flags: flags_now, hvc: hvc_count};
            tx_state_q <= ACOM_TX_ID;
          end
        end
        ACOM_TX_ID:   if (tx_ready) tx_state_q <= ACOM_TX_FLAG;
        ACOM_TX_FLAG: if (tx_ready) tx_state_q <= ACOM_TX_HI;
        ACOM_TX_HI:   if (tx_ready) tx_state_q <= ACOM_TX_LO;
        ACOM_TX_LO:   if (tx_ready) tx_state_q <= ACOM_TX_IDLE;
        default:      tx_state_q <= ACOM_TX_IDLE;
      endcase
    end
  end

  always_comb begin
    tx_octet = '0;
    case (tx_state_q)
      ACOM_TX_ID:   tx_octet = '{valid: 1'b1, data: ACOM_ID_STATUS, last: 1'b0};
      ACOM_TX_FLAG: tx_octet = '{valid: 1'b1, data: snap_q.flags, last: 1'b0};
      ACOM_TX_HI:   tx_octet = '{valid: 1'b1, data: snap_q.hvc[15:8], last: 1'b0};
      ACOM_TX_LO:   tx_octet = '{valid: 1'b1, data: snap_q.hvc[7:0], last: 1'b1};
      default:      tx_octet = '0;
    endcase
  end

endmodule : acom_monitor

//--- acom_monitor_chk.sv
// Port checker for the cell OAM monitor
`timescale 1ns/100ps
module acom_monitor_chk
  import acom_pkg::*;
#(
  parameter longint TICK_CYC = ACOM_TICK_CYC
) (
  input wire logic   clk,
  input wire logic   reset_n,
  input wire logic   clk_en,
  input wire logic   data_mode,
  input acom_delin_t delin_state,
  input wire logic   cell_valid,
  input wire logic   hec_error,
  input wire logic   htc_clear,
  input acom_octet_t rx_octet,
  input acom_octet_t tx_octet,
  input wire logic   tx_ready,
  input logic [15:0] hvc_count,
  input logic [31:0] htc_count,
  input logic        no_delin_flag,
  input logic        near_ncd_fail
);
  logic [1:0]  idx_q;
  logic [31:0] run_q;
  ////////////////////////////////////////
  // Octet position within a status frame
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) idx_q <= 2'h0;
    else if (tx_octet.valid && tx_ready) idx_q <= tx_octet.last ? 2'h0 : idx_q + 2'h1;
  end
  // Anomaly run length, zeroed outside data mode
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) run_q <= 32'h0;
    else if (!(no_delin_flag && data_mode)) run_q <= 32'h0;
    else if (clk_en) run_q <= run_q + 32'h1;
  end
  ////////////////////////////////////////
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  chk_hvc_step: assert property (
    clk_en && hec_error |=> hvc_count == $past(hvc_count) + 16'h0001)
    else $error("hvc did not step");
  chk_hvc_hold: assert property (
    !(clk_en && hec_error) |=> $stable(hvc_count))
    else $error("hvc moved without error");
  chk_htc_step: assert property (
    clk_en && cell_valid && delin_state == ACOM_SYNC && !htc_clear
    |=> htc_count == $past(htc_count) + 32'h1) else $error("htc did not step");
  chk_frame_id: assert property (
    tx_octet.valid && idx_q == 2'h0 |-> tx_octet.data == ACOM_ID_STATUS)
    else $error("frame id wrong");
  chk_flag_single: assert property (
    tx_octet.valid && idx_q == 2'h1 |-> $onehot0(tx_octet.data[7:5])
    && tx_octet.data[4:2] == 3'h0) else $error("flag octet malformed");
  chk_last_octet: assert property (
    tx_octet.valid |-> tx_octet.last == (idx_q == 2'h3))
    else $error("last marker misplaced");
  chk_octet_hold: assert property (
    tx_octet.valid && !tx_ready |=> tx_octet.valid && $stable(tx_octet.data))
    else $error("octet dropped before taken");
  chk_req_reply: assert property (
    rx_octet.valid && rx_octet.last && rx_octet.data == ACOM_ID_REQ && !tx_octet.valid
    |-> ##[1:3] tx_octet.valid) else $error("request not answered");
  chk_ncd_persist: assert property (
    $rose(near_ncd_fail) |-> run_q >= 24 * TICK_CYC - 2)
    else $error("ncd failure declared early");
endmodule : acom_monitor_chk

bind acom_monitor acom_monitor_chk #(.TICK_CYC(TICK_CYC)) i_chk (
  .clk(clk), .reset_n(reset_n), .clk_en(clk_en), .data_mode(data_mode),
  .delin_state(delin_state), .cell_valid(cell_valid), .hec_error(hec_error),
  .htc_clear(htc_clear), .rx_octet(rx_octet), .tx_octet(tx_octet),
  .tx_ready(tx_ready), .hvc_count(hvc_count), .htc_count(htc_count),
  .no_delin_flag(no_delin_flag), .near_ncd_fail(near_ncd_fail));

//--- acom_far_end.sv
// Far-end transceiver model: takes status frames, sends messages
`timescale 1ns/100ps
module acom_far_end
  import acom_pkg::*;
(
  input wire logic   clk,
  input acom_octet_t tx_octet,
  output logic       tx_ready,
  output acom_octet_t rx_octet,
  input wire logic   slow
);
  logic [7:0]  oct_q [4];
  logic [15:0] prev_hvc = 16'h0000;
  logic        hec_ind = 1'b0;
  logic        tog_q = 1'b0;
  int          idx = 0;
  int          frames = 0;
  initial rx_octet = '0;
  ////////////////////////////////////////
  // Slow mode stalls every other cycle
  always_ff @(posedge clk) tog_q <= ~tog_q;
  assign tx_ready = !slow || tog_q;
  // hec inferred from count change
  // Non-blocking so bench reads at an edge never race the capture
  always @(posedge clk) begin
    if (tx_octet.valid && tx_ready) begin
      if (idx < 4) oct_q[idx] <= tx_octet.data;
      idx <= tx_octet.last ? 0 : idx + 1;
      if (tx_octet.last) begin
        frames   <= frames + 1;
        hec_ind  <= ({oct_q[2], tx_octet.data} != prev_hvc);
        prev_hvc <= {oct_q[2], tx_octet.data};
      end
    end
  end
  task automatic send(input logic [7:0] d, input logic lst);
    @(posedge clk);
    rx_octet <= '{1'b1, d, lst};
    @(posedge clk);
    // Released line shows inverted data
    rx_octet <= '{1'b0, ~d, 1'b0};
  endtask : send
endmodule : acom_far_end

//--- acom_monitor_tb.sv
// Self-checking bench for the cell OAM monitor
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin fails++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module acom_monitor_tb
  import acom_pkg::*;
;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        data_mode = 1'b0;
  acom_delin_t delin_state = ACOM_HUNT;
  logic        cell_valid = 1'b0;
  logic        hec_error = 1'b0;
  logic        frame_strobe = 1'b0;
  logic        htc_clear = 1'b0;
  logic        slow = 1'b0;
  logic        clk_en = 1'b1;
  logic        sync_word_lost = 1'b0;
  acom_octet_t rx_octet, tx_octet;
  logic        tx_ready;
  logic [15:0] hvc_count;
  logic [31:0] htc_count;
  logic        no_delin_flag, out_delin_flag, loss_delin_flag;
  logic        near_ncd_fail, near_lcd_fail, far_ncd_fail, far_lcd_fail;
  int          fails = 0;
  int          checks_done = 0;
  ////////////////////////////////////////
  // Short tick so one second is 100 cycles
  acom_monitor #(.TICK_CYC(10)) i_dut (
    .clk(clk), .reset_n(reset_n), .clk_en(clk_en), .data_mode(data_mode),
    .delin_state(delin_state), .cell_valid(cell_valid), .hec_error(hec_error),
    .frame_strobe(frame_strobe), .sync_word_lost(sync_word_lost), .rx_octet(rx_octet),
    .tx_octet(tx_octet), .tx_ready(tx_ready), .hvc_count(hvc_count),
    .htc_count(htc_count), .htc_clear(htc_clear), .no_delin_flag(no_delin_flag),
    .out_delin_flag(out_delin_flag), .loss_delin_flag(loss_delin_flag),
    .near_ncd_fail(near_ncd_fail), .near_lcd_fail(near_lcd_fail),
    .far_ncd_fail(far_ncd_fail), .far_lcd_fail(far_lcd_fail));
  acom_far_end i_far (.clk(clk), .tx_octet(tx_octet), .tx_ready(tx_ready),
    .rx_octet(rx_octet), .slow(slow));
  initial forever #2.5 clk = ~clk;
  ////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic far_status(input logic [7:0] fl);
    i_far.send(ACOM_ID_STATUS, 1'b0);
    i_far.send(fl, 1'b0);
    i_far.send(8'h00, 1'b0);
    i_far.send(8'h05, 1'b1);
  endtask : far_status
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize
  // Tests need about 68000 cycles
  initial begin
    cyc(80000);
    fails++;
    summarize();
  end
  initial begin
    cyc(12);
    reset_n <= 1'b1;
    cyc(2);
    `CHK("no_delin", 1'b1, no_delin_flag)
    hec_error <= 1'b1;
    cyc(65538);
    hec_error <= 1'b0;
    cyc(2);
    `CHK("hvc", 16'h0002, hvc_count)
    `CHK("ncd_fail", 1'b0, near_ncd_fail)
    data_mode <= 1'b1;
    slow <= 1'b1;
    cyc(190);
    `CHK("ncd_fail", 1'b0, near_ncd_fail)
    cyc(110);
    `CHK("ncd_fail", 1'b1, near_ncd_fail)
    `CHK("far_ncd", 1'b1, far_ncd_fail)
    `CHK("frames", 1, i_far.frames)
    `CHK("id", 8'h91, i_far.oct_q[0])
    `CHK("flags", 8'h82, i_far.oct_q[1])
    `CHK("hvc_tx", 16'h0002, {i_far.oct_q[2], i_far.oct_q[3]})
    cyc(100);
    `CHK("frames", 2, i_far.frames)
    i_far.send(ACOM_ID_REQ, 1'b1);
    cyc(20);
    `CHK("frames", 3, i_far.frames)
    `CHK("hec_ind", 1'b0, i_far.hec_ind)
    cyc(250);
    `CHK("frames", 3, i_far.frames)
    far_status(8'h20);
    cyc(310);
    `CHK("far_lcd", 1'b1, far_lcd_fail)
    `CHK("far_ncd", 1'b1, far_ncd_fail)
    cell_valid <= 1'b1;
    cyc(3);
    delin_state <= ACOM_SYNC;
    cyc(4);
    cell_valid <= 1'b0;
    cyc(2);
    `CHK("htc", 32'h0000_0004, htc_count)
    `CHK("no_delin", 1'b0, no_delin_flag)
    htc_clear <= 1'b1;
    cyc(1);
    htc_clear <= 1'b0;
    cyc(2);
    `CHK("htc", 32'h0000_0000, htc_count)
    delin_state <= ACOM_HUNT;
    cyc(3);
    `CHK("out_delin", 1'b1, out_delin_flag)
    for (int i = 0; i < 9; i++) begin
      if (i == 8) `CHK("loss_delin", 1'b0, loss_delin_flag)
      frame_strobe <= 1'b1;
      cyc(1);
      frame_strobe <= 1'b0;
      cyc(3);
    end
    `CHK("loss_delin", 1'b1, loss_delin_flag)
    cyc(310);
    `CHK("lcd_fail", 1'b1, near_lcd_fail)
    `CHK("flags", 8'h23, i_far.oct_q[1])
    delin_state <= ACOM_PRESYNC;
    cyc(2);
    delin_state <= ACOM_SYNC;
    frame_strobe <= 1'b1;
    cyc(1);
    frame_strobe <= 1'b0;
    far_status(8'h00);
    cyc(940);
    `CHK("lcd_fail", 1'b1, near_lcd_fail)
    cyc(120);
    `CHK("lcd_fail", 1'b0, near_lcd_fail)
    `CHK("ncd_fail", 1'b0, near_ncd_fail)
    `CHK("far_ncd", 1'b0, far_ncd_fail)
    `CHK("far_lcd", 1'b0, far_lcd_fail)
    // Sync-word loss vetoes the loss defect
    sync_word_lost <= 1'b1;
    delin_state    <= ACOM_HUNT;
    for (int i = 0; i < 10; i++) begin
      frame_strobe <= 1'b1;
      cyc(1);
      frame_strobe <= 1'b0;
      cyc(3);
    end
    `CHK("loss_veto", 1'b0, loss_delin_flag)
    `CHK("out_delin", 1'b1, out_delin_flag)
    // Low clock enable freezes the counts
    clk_en    <= 1'b0;
    hec_error <= 1'b1;
    cyc(3);
    hec_error <= 1'b0;
    clk_en    <= 1'b1;
    cyc(2);
    `CHK("hvc_frozen", 16'h0002, hvc_count)
    summarize();
  end
endmodule : acom_monitor_tb
